// ### hdl/trace_cfg_pkg.sv
package trace_cfg_pkg;

  // Register byte offsets
  localparam logic [7:0] off_cmd        = 8'h00;
  localparam logic [7:0] off_arg        = 8'h04;
  localparam logic [7:0] off_result     = 8'h08;
  localparam logic [7:0] off_config     = 8'h0c;
  localparam logic [7:0] off_count      = 8'h10;
  localparam logic [7:0] off_thresh     = 8'h14;
  localparam logic [7:0] off_int_status = 8'h18;
  localparam logic [7:0] off_int_mask   = 8'h1c;

  // Term limits
  localparam logic [3:0] easy_max_terms    = 4'h4;
  localparam logic [3:0] complex_max_terms = 4'h8;

  // Limits of values, thresholds in units of 10 mV
  localparam logic [31:0]        count_min  = 32'h0000_0001;
  localparam logic [31:0]        count_max  = 32'h0000_ffff;
  localparam logic signed [15:0] thresh_min = -16'sh0280;
  localparam logic signed [15:0] thresh_max = 16'sh027b;
  localparam logic signed [15:0] thresh_step = 16'sh0005;

  // Reset values
  localparam logic [15:0] count_reset  = 16'h0001;
  localparam logic [15:0] thresh_reset = 16'h0000;

  // Error codes, 0 means accepted
  localparam logic [15:0] err_none          = 16'h0000;
  localparam logic [15:0] err_unknown_op    = 16'h0001;
  localparam logic [15:0] err_range_in_use  = 16'h04c5;
  localparam logic [15:0] err_term_range    = 16'h04c8;
  localparam logic [15:0] err_not_contig    = 16'h04c9;
  localparam logic [15:0] err_too_many      = 16'h04ca;
  localparam logic [15:0] err_not_defined   = 16'h04cb;
  localparam logic [15:0] err_one_required  = 16'h04cc;
  localparam logic [15:0] err_bad_count     = 16'h04d2;
  localparam logic [15:0] err_bad_thresh    = 16'h04d3;
  localparam logic [15:0] err_duplicate     = 16'h04d5;
  localparam logic [15:0] err_speed_vs_cq   = 16'h04d7;
  localparam logic [15:0] err_cq_vs_speed   = 16'h04d8;

  // Interrupt status bits
  localparam int irq_accepted = 0;
  localparam int irq_rejected = 1;

  typedef enum logic [3:0] {
    op_mode    = 4'h0,
    op_insert  = 4'h1,
    op_delete  = 4'h2,
    op_primary = 4'h3,
    op_qualify = 4'h4,
    op_range   = 4'h5,
    op_count   = 4'h6,
    op_thresh  = 4'h7,
    op_speed   = 4'h8,
    op_cq      = 4'h9
  } op_type;

  typedef enum logic [1:0] {
    slow_speed      = 2'h0,
    fast_speed      = 2'h1,
    very_fast_speed = 2'h2
  } speed_type;

  typedef enum logic [1:0] {
    cq_none  = 2'h0,
    cq_time  = 2'h1,
    cq_state = 2'h2
  } cq_type;

  typedef struct packed {
    logic [16:0] rsvd;
    logic [1:0]  lower_times;
    logic [1:0]  upper_times;
    logic        uses_range;
    logic [1:0]  sel;
    logic [3:0]  term;
    op_type      op;
  } cmd_type;

  typedef struct packed {
    logic signed [15:0] lower;
    logic signed [15:0] upper;
  } thresh_type;

endpackage

// ### hdl/trace_sequencer_config_checker.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Easy mode holds at most four terms; inserting a fifth is refused.
// - Complex mode always provides exactly eight terms.
// - Qualification naming a term beyond the limit is refused as out of range.
// - Insert only between existing terms or directly after the last.
// - Delete or primary branch of an undefined term is refused.
// - Deleting while only one term exists is refused.
// - Occurrence count accepted only from 1 to 65535.
// - Threshold accepted only from -6.4 V to +6.35 V in 0.05 V steps.
// - Upper or lower threshold given twice in one command is refused.
// - Easy mode allows one range expression; a different second is refused.
// - Complex range redefinition refused while any term references it.
// - Fast or very fast speed refused while counting time.
// - Very fast speed refused while counting states.
// - Counting time refused while speed is fast or very fast.
// - Counting states refused while speed is fast.
module trace_sequencer_config_checker (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  trace_cfg_pkg::cmd_type    cmd;
  trace_cfg_pkg::cmd_type    last_cmd;
  trace_cfg_pkg::thresh_type arg_thresh;
  trace_cfg_pkg::thresh_type thresh;
  trace_cfg_pkg::speed_type  speed;
  trace_cfg_pkg::cq_type     cq;
  logic [31:0] arg;
  logic        complex_mode;
  logic [3:0]  term_count;
  logic [3:0]  term_limit;
  logic [7:0]  range_ref;
  logic        range_used;
  logic [15:0] range_val;
  logic [15:0] occ_count;
  logic [15:0] result;
  logic [1:0]  int_status;
  logic [1:0]  int_mask;
  logic [15:0] next_err;
  logic        access;
  logic        fire;
  logic        accept;
  logic        mapped;
  logic        range_clash;

  assign access     = psel && penable;
  assign fire       = access && pwrite && paddr == trace_cfg_pkg::off_cmd;
  assign accept     = fire && next_err == trace_cfg_pkg::err_none;
  assign cmd        = trace_cfg_pkg::cmd_type'(pwdata);
  assign arg_thresh = trace_cfg_pkg::thresh_type'(arg);
  assign term_limit = complex_mode ? trace_cfg_pkg::complex_max_terms
                                   : trace_cfg_pkg::easy_max_terms;
  // Zero wait states keep every command a single-edge decision
  assign pready     = 1'b1;
  assign irq        = |(int_status & int_mask);

  // Easy mode: a different second range expression clashes
  assign range_clash = !complex_mode && range_used && arg[15:0] != range_val;

  function automatic logic thresh_ok(input logic signed [15:0] v);
    logic signed [15:0] r;
    r = v % trace_cfg_pkg::thresh_step;
    return v >= trace_cfg_pkg::thresh_min && v <= trace_cfg_pkg::thresh_max
           && r == 16'sh0000;
  endfunction

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      trace_cfg_pkg::off_cmd,
      trace_cfg_pkg::off_arg,
      trace_cfg_pkg::off_result,
      trace_cfg_pkg::off_config,
      trace_cfg_pkg::off_count,
      trace_cfg_pkg::off_thresh,
      trace_cfg_pkg::off_int_status,
      trace_cfg_pkg::off_int_mask: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = access && !mapped;

  // Command check, first failing check gives the code
  always_comb begin
    next_err = trace_cfg_pkg::err_none;
    case (cmd.op)
      trace_cfg_pkg::op_mode: begin
        next_err = trace_cfg_pkg::err_none;
      end
      trace_cfg_pkg::op_insert: begin
        if (complex_mode || term_count == trace_cfg_pkg::easy_max_terms) begin
          next_err = trace_cfg_pkg::err_too_many;
        // Position one would sit before the first term, not between two
        end else if (cmd.term < 4'h2 || cmd.term > term_count + 4'h1) begin
          next_err = trace_cfg_pkg::err_not_contig;
        end
      end
      trace_cfg_pkg::op_delete: begin
        if (cmd.term == 4'h0 || cmd.term > term_limit) begin
          next_err = trace_cfg_pkg::err_term_range;
        end else if (cmd.term > term_count) begin
          next_err = trace_cfg_pkg::err_not_defined;
        end else if (complex_mode || term_count == 4'h1) begin
          next_err = trace_cfg_pkg::err_one_required;
        end
      end
      trace_cfg_pkg::op_primary: begin
        if (cmd.term == 4'h0 || cmd.term > term_limit) begin
          next_err = trace_cfg_pkg::err_term_range;
        end else if (cmd.term > term_count) begin
          next_err = trace_cfg_pkg::err_not_defined;
        end else if (cmd.uses_range && range_clash) begin
          next_err = trace_cfg_pkg::err_range_in_use;
        end
      end
      trace_cfg_pkg::op_qualify: begin
        if (cmd.term == 4'h0 || cmd.term > term_count) begin
          next_err = trace_cfg_pkg::err_term_range;
        end else if (cmd.uses_range && range_clash) begin
          next_err = trace_cfg_pkg::err_range_in_use;
        end
      end
      trace_cfg_pkg::op_range: begin
        if (complex_mode && |range_ref) begin
          next_err = trace_cfg_pkg::err_range_in_use;
        end else if (range_clash) begin
          next_err = trace_cfg_pkg::err_range_in_use;
        end
      end
      trace_cfg_pkg::op_count: begin
        if (arg < trace_cfg_pkg::count_min || arg > trace_cfg_pkg::count_max) begin
          next_err = trace_cfg_pkg::err_bad_count;
        end
      end
      trace_cfg_pkg::op_thresh: begin
        if (cmd.upper_times > 2'h1 || cmd.lower_times > 2'h1) begin
          next_err = trace_cfg_pkg::err_duplicate;
        end else if ((cmd.upper_times == 2'h1 && !thresh_ok(arg_thresh.upper)) ||
                     (cmd.lower_times == 2'h1 && !thresh_ok(arg_thresh.lower))) begin
          next_err = trace_cfg_pkg::err_bad_thresh;
        end
      end
      trace_cfg_pkg::op_speed: begin
        if (cq == trace_cfg_pkg::cq_time &&
            (cmd.sel == trace_cfg_pkg::fast_speed ||
             cmd.sel == trace_cfg_pkg::very_fast_speed)) begin
          next_err = trace_cfg_pkg::err_speed_vs_cq;
        end else if (cq == trace_cfg_pkg::cq_state &&
                     cmd.sel == trace_cfg_pkg::very_fast_speed) begin
          next_err = trace_cfg_pkg::err_speed_vs_cq;
        end else if (cmd.sel > trace_cfg_pkg::very_fast_speed) begin
          next_err = trace_cfg_pkg::err_unknown_op;
        end
      end
      trace_cfg_pkg::op_cq: begin
        if (cmd.sel == trace_cfg_pkg::cq_time && speed != trace_cfg_pkg::slow_speed) begin
          next_err = trace_cfg_pkg::err_cq_vs_speed;
        end else if (cmd.sel == trace_cfg_pkg::cq_state &&
                     speed == trace_cfg_pkg::fast_speed) begin
          next_err = trace_cfg_pkg::err_cq_vs_speed;
        end else if (cmd.sel > trace_cfg_pkg::cq_state) begin
          next_err = trace_cfg_pkg::err_unknown_op;
        end
      end
      default: next_err = trace_cfg_pkg::err_unknown_op;
    endcase
  end

  // Sequencer terms and mode; updates only on accept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complex_mode <= 1'b0;
      term_count   <= 4'h1;
    end else if (accept) begin
      case (cmd.op)
        trace_cfg_pkg::op_mode: begin
          complex_mode <= cmd.sel[0];
          term_count   <= cmd.sel[0] ? trace_cfg_pkg::complex_max_terms : 4'h1;
        end
        trace_cfg_pkg::op_insert: term_count <= term_count + 4'h1;
        trace_cfg_pkg::op_delete: term_count <= term_count - 4'h1;
        default: term_count <= term_count;
      endcase
    end
  end

  // Range resource and its references
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_ref  <= 8'h00;
      range_used <= 1'b0;
      range_val  <= 16'h0000;
    end else if (accept) begin
      case (cmd.op)
        trace_cfg_pkg::op_mode: begin
          range_ref  <= 8'h00;
          range_used <= 1'b0;
        end
        trace_cfg_pkg::op_primary,
        trace_cfg_pkg::op_qualify: begin
          if (complex_mode) begin
            range_ref[cmd.term[2:0] - 3'h1] <= cmd.uses_range;
          end else if (cmd.uses_range) begin
            range_used <= 1'b1;
            range_val  <= arg[15:0];
          end
        end
        trace_cfg_pkg::op_range: begin
          range_used <= !complex_mode;
          range_val  <= arg[15:0];
        end
        default: range_used <= range_used;
      endcase
    end
  end

  // Count, threshold, speed and count qualifier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      occ_count <= trace_cfg_pkg::count_reset;
      thresh    <= {trace_cfg_pkg::thresh_reset, trace_cfg_pkg::thresh_reset};
      speed     <= trace_cfg_pkg::slow_speed;
      cq        <= trace_cfg_pkg::cq_none;
    end else if (accept) begin
      case (cmd.op)
        trace_cfg_pkg::op_count: occ_count <= arg[15:0];
        trace_cfg_pkg::op_thresh: begin
          if (cmd.upper_times == 2'h1) begin
            thresh.upper <= arg_thresh.upper;
          end
          if (cmd.lower_times == 2'h1) begin
            thresh.lower <= arg_thresh.lower;
          end
        end
        trace_cfg_pkg::op_speed: speed <= trace_cfg_pkg::speed_type'(cmd.sel);
        trace_cfg_pkg::op_cq:    cq    <= trace_cfg_pkg::cq_type'(cmd.sel);
        default: cq <= cq;
      endcase
    end
  end

  // Result code of the last command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result   <= trace_cfg_pkg::err_none;
      last_cmd <= '0;
    end else if (fire) begin
      result   <= next_err;
      last_cmd <= cmd;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arg      <= 32'h0000_0000;
      int_mask <= 2'h0;
    end else if (access && pwrite) begin
      if (paddr == trace_cfg_pkg::off_arg) begin
        arg <= pwdata;
      end
      if (paddr == trace_cfg_pkg::off_int_mask) begin
        int_mask <= pwdata[1:0];
      end
    end
  end

  // Sticky events; a new event beats the read that clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= 2'h0;
    end else begin
      if (access && !pwrite && paddr == trace_cfg_pkg::off_int_status) begin
        int_status <= 2'h0;
      end
      if (fire) begin
        int_status[trace_cfg_pkg::irq_accepted] <= accept;
        int_status[trace_cfg_pkg::irq_rejected] <= !accept;
      end
      if (fire && !(access && !pwrite && paddr == trace_cfg_pkg::off_int_status)) begin
        int_status[trace_cfg_pkg::irq_accepted] <=
          accept || int_status[trace_cfg_pkg::irq_accepted];
        int_status[trace_cfg_pkg::irq_rejected] <=
          !accept || int_status[trace_cfg_pkg::irq_rejected];
      end
    end
  end

  // Read data taken from flip-flops only
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      trace_cfg_pkg::off_cmd:        prdata = last_cmd;
      trace_cfg_pkg::off_arg:        prdata = arg;
      trace_cfg_pkg::off_result:     prdata = {16'h0000, result};
      // Only the low fourteen bits of the range value fit beside the rest
      trace_cfg_pkg::off_config:     prdata = {range_val[13:0], range_ref, range_used, cq,
                                               speed, complex_mode, term_count};
      trace_cfg_pkg::off_count:      prdata = {16'h0000, occ_count};
      trace_cfg_pkg::off_thresh:     prdata = thresh;
      trace_cfg_pkg::off_int_status: prdata = {30'h0000_0000, int_status};
      trace_cfg_pkg::off_int_mask:   prdata = {30'h0000_0000, int_mask};
      default:                       prdata = 32'h0000_0000;
    endcase
  end

  logic irq_rej_seen;
  assign irq_rej_seen = int_status[trace_cfg_pkg::irq_rejected];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  easy_limit_a: assert property (!complex_mode |-> term_count <= 4'h4 && term_count >= 4'h1)
    else $error("easy term count out of bounds");

  complex_eight_a: assert property (complex_mode |-> term_count == 4'h8)
    else $error("complex mode lost its eight terms");

  term_range_a: assert property (fire && cmd.op == trace_cfg_pkg::op_qualify &&
                                 cmd.term > term_count
                                 |=> result == 16'h04c8)
    else $error("out of range term accepted");

  insert_pos_a: assert property (fire && cmd.op == trace_cfg_pkg::op_insert &&
                                 !complex_mode && term_count < 4'h4 &&
                                 cmd.term > term_count + 4'h1
                                 |=> result == 16'h04c9 && $stable(term_count))
    else $error("non contiguous insert accepted");

  undefined_a: assert property (fire && cmd.op == trace_cfg_pkg::op_delete &&
                                !complex_mode && cmd.term > term_count && cmd.term <= 4'h4
                                |=> result == 16'h04cb)
    else $error("undefined term not refused");

  one_term_a: assert property (fire && cmd.op == trace_cfg_pkg::op_delete &&
                               !complex_mode && term_count == 4'h1 && cmd.term == 4'h1
                               |=> result == 16'h04cc ##1 term_count == 4'h1)
    else $error("last term deleted");

  count_range_a: assert property (fire && cmd.op == trace_cfg_pkg::op_count &&
                                  (arg == 32'h0 || arg > 32'h0000_ffff)
                                  |=> result == 16'h04d2 && $stable(occ_count))
    else $error("bad occurrence count accepted");

  dup_option_a: assert property (fire && cmd.op == trace_cfg_pkg::op_thresh &&
                                 cmd.upper_times > 2'h1
                                 |=> result == 16'h04d5 && $stable(thresh))
    else $error("duplicated threshold accepted");

  range_busy_a: assert property (fire && cmd.op == trace_cfg_pkg::op_range &&
                                 complex_mode && |range_ref
                                 |=> result == 16'h04c5 && $stable(range_val))
    else $error("referenced range redefined");

  speed_cq_a: assert property (fire && cmd.op == trace_cfg_pkg::op_speed &&
                               cq == trace_cfg_pkg::cq_state &&
                               cmd.sel == trace_cfg_pkg::very_fast_speed
                               |=> result == 16'h04d7 && $stable(speed))
    else $error("very fast speed with counting");

  cq_speed_a: assert property (cq == trace_cfg_pkg::cq_time |->
                               speed == trace_cfg_pkg::slow_speed)
    else $error("time count with fast speed");

  reject_hold_a: assert property (fire && next_err != 16'h0000
                                  |=> $stable(occ_count) && $stable(term_count) &&
                                      $stable(speed) && $stable(cq) && irq_rej_seen)
    else $error("rejected command changed configuration");

  insert_ok_c:  cover property (accept && cmd.op == trace_cfg_pkg::op_insert);
  full_easy_c:  cover property (!complex_mode && term_count == 4'h4);
  range_busy_c: cover property (fire && next_err == trace_cfg_pkg::err_range_in_use);
  irq_c:        cover property (irq ##1 !irq);

endmodule

// ### test/apb_host.sv
`timescale 1ns/1ps
module apb_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Waits on pready alone; only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule

// ### test/trace_sequencer_config_checker_tb.sv
`timescale 1ns/1ps
module trace_sequencer_config_checker_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] d;
  logic        e;
  logic [31:0] cv [4] = '{32'h0, 32'h1, 32'hffff, 32'h1_0000};
  logic [31:0] tv [5] = '{32'hfd80_027b, 32'h0000_0280, 32'hfd7b_0000, 32'h3_0005,
                          32'h5_fffb};
  int num_errors = 0, total_checks = 0, seed = 75012;
  int cpx = 0, nt = 1, rv = -1, rf = 0, cnt = 1, tup = 0, tlo = 0, spd = 0, cq = 0;
  int ist = 0, ur = 0, ut = 1, lt = 1;

  trace_sequencer_config_checker u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic test_done();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] t;
    u_host.xfer(1'b1, a, v, t, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    u_host.xfer(1'b0, a, 32'h0, v, e);
  endtask

  task automatic state();
    rd(trace_cfg_pkg::off_count, d);
    chk("count", 32'(cnt), d);
    rd(trace_cfg_pkg::off_thresh, d);
    chk("thresh", {16'(tlo), 16'(tup)}, d);
    rd(trace_cfg_pkg::off_config, d);
    chk("config", {14'h0, 8'(rf >> 1), rv >= 0 && cpx == 0, 2'(cq), 2'(spd), cpx[0],
                   4'(nt)}, {14'h0, d[17:0]});
  endtask

  function automatic bit okt(input int v);
    return v >= trace_cfg_pkg::thresh_min && v <= trace_cfg_pkg::thresh_max && v % 5 == 0;
  endfunction

  // Reference model first, then the design sees the same command
  task automatic cmd(input trace_cfg_pkg::op_type o, input int t, input int s,
                     input logic [31:0] a);
    trace_cfg_pkg::cmd_type c;
    logic [15:0] x;
    int hi;
    int lo;
    c = '0;
    c.op = o;
    c.term = 4'(t);
    c.sel = 2'(s);
    c.uses_range = ur[0];
    c.upper_times = 2'(ut);
    c.lower_times = 2'(lt);
    x = trace_cfg_pkg::err_none;
    hi = $signed(a[15:0]);
    lo = $signed(a[31:16]);
    case (o)
      trace_cfg_pkg::op_mode: begin
        cpx = s % 2;
        nt = cpx ? 8 : 1;
        rf = 0;
        rv = -1;
      end
      trace_cfg_pkg::op_insert:
        if (cpx) x = trace_cfg_pkg::err_too_many;
        else if (t < 2 || t > nt + 1) x = trace_cfg_pkg::err_not_contig;
        else if (nt == 4) x = trace_cfg_pkg::err_too_many;
        else nt++;
      trace_cfg_pkg::op_delete:
        if (cpx || t <= nt && nt == 1) x = trace_cfg_pkg::err_one_required;
        else if (t > nt) x = trace_cfg_pkg::err_not_defined;
        else nt--;
      trace_cfg_pkg::op_primary:
        if (t > nt) x = trace_cfg_pkg::err_not_defined;
      trace_cfg_pkg::op_qualify:
        if (t > nt) x = trace_cfg_pkg::err_term_range;
        else rf[t] = ur[0];
      trace_cfg_pkg::op_range:
        if (cpx ? rf != 0 : rv >= 0 && rv != a[15:0]) x = trace_cfg_pkg::err_range_in_use;
        else rv = a[15:0];
      trace_cfg_pkg::op_count:
        if (a < trace_cfg_pkg::count_min || a > trace_cfg_pkg::count_max)
          x = trace_cfg_pkg::err_bad_count;
        else cnt = a;
      trace_cfg_pkg::op_thresh:
        if (ut > 1 || lt > 1) x = trace_cfg_pkg::err_duplicate;
        else if (!okt(hi) || !okt(lo)) x = trace_cfg_pkg::err_bad_thresh;
        else begin
          tup = hi;
          tlo = lo;
        end
      trace_cfg_pkg::op_speed:
        if (s > 0 && cq == 1 || s == 2 && cq == 2) x = trace_cfg_pkg::err_speed_vs_cq;
        else spd = s;
      trace_cfg_pkg::op_cq:
        if (s == 1 && spd > 0 || s == 2 && spd == 1) x = trace_cfg_pkg::err_cq_vs_speed;
        else cq = s;
      default: x = trace_cfg_pkg::err_unknown_op;
    endcase
    ist |= x == 0 ? 1 : 2;
    wr(trace_cfg_pkg::off_arg, a);
    wr(trace_cfg_pkg::off_cmd, c);
    rd(trace_cfg_pkg::off_result, d);
    chk("result", {16'h0, x}, d);
    rd(trace_cfg_pkg::off_cmd, d);
    chk("last_cmd", c, d);
  endtask

  initial begin
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    state();
    rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    chk("slverr", 32'h1, {31'h0, e});
    wr(8'h24, 32'hffff_ffff);
    wr(trace_cfg_pkg::off_int_mask, 32'h2);
    rd(trace_cfg_pkg::off_int_mask, d);
    chk("int_mask", 32'h2, d);
    cmd(trace_cfg_pkg::op_insert, 1, 0, 0);
    cmd(trace_cfg_pkg::op_insert, 3, 0, 0);
    for (int i = 2; i <= 5; i++) cmd(trace_cfg_pkg::op_insert, i == 5 ? 4 : i, 0, 0);
    state();
    cmd(trace_cfg_pkg::op_primary, 4, 0, 0);
    cmd(trace_cfg_pkg::op_qualify, 4, 0, 0);
    for (int i = 4; i >= 1; i--) cmd(trace_cfg_pkg::op_delete, i, 0, 0);
    cmd(trace_cfg_pkg::op_delete, 3, 0, 0);
    cmd(trace_cfg_pkg::op_primary, 2, 0, 0);
    cmd(trace_cfg_pkg::op_qualify, 3, 0, 0);
    state();
    @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(trace_cfg_pkg::off_int_status, d);
    chk("int_status", 32'(ist), d);
    ist = 0;
    @(negedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    for (int i = 0; i < 3; i++) begin
      cmd(trace_cfg_pkg::op_range, 0, 0, i == 2 ? 'h4321 : 'h1234);
    end
    cmd(trace_cfg_pkg::op_mode, 0, 1, 0);
    state();
    cmd(trace_cfg_pkg::op_insert, 5, 0, 0);
    cmd(trace_cfg_pkg::op_delete, 8, 0, 0);
    cmd(trace_cfg_pkg::op_primary, 8, 0, 0);
    cmd(trace_cfg_pkg::op_qualify, 9, 0, 0);
    cmd(trace_cfg_pkg::op_range, 0, 0, 32'h10);
    for (int i = 1; i >= 0; i--) begin
      ur = i;
      cmd(trace_cfg_pkg::op_qualify, 3, 0, 0);
      state();
      cmd(trace_cfg_pkg::op_range, 0, 0, 32'h20);
    end
    foreach (cv[i]) cmd(trace_cfg_pkg::op_count, 0, 0, cv[i]);
    for (int i = 0; i < 8; i++) begin
      cmd(trace_cfg_pkg::op_count, 0, 0, $random(seed) & 32'h1_ffff);
      state();
    end
    foreach (tv[i]) cmd(trace_cfg_pkg::op_thresh, 0, 0, tv[i]);
    for (int i = 0; i < 6; i++) begin
      cmd(trace_cfg_pkg::op_thresh, 0, 0, {16'($random(seed) % 140 * 5),
                                           16'($random(seed) % 140 * 5)});
      state();
    end
    for (int j = 1; j <= 2; j++) begin
      ut = j == 1 ? 2 : 1;
      lt = j == 2 ? 2 : 1;
      cmd(trace_cfg_pkg::op_thresh, 0, 0, 32'h5_0005);
    end
    ut = 1;
    lt = 1;
    state();
    // Masked event class must not raise the line
    wr(trace_cfg_pkg::off_int_mask, 32'h1);
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 3; s++) begin
        cmd(trace_cfg_pkg::op_speed, 0, 0, 0);
        cmd(trace_cfg_pkg::op_cq, 0, 0, 0);
        cmd(trace_cfg_pkg::op_cq, 0, c, 0);
        cmd(trace_cfg_pkg::op_speed, 0, s, 0);
        cmd(trace_cfg_pkg::op_speed, 0, 0, 0);
        cmd(trace_cfg_pkg::op_cq, 0, 0, 0);
        cmd(trace_cfg_pkg::op_speed, 0, s, 0);
        cmd(trace_cfg_pkg::op_cq, 0, c, 0);
        state();
      end
    end
    cmd(trace_cfg_pkg::op_type'(4'ha), 0, 0, 0);
    rd(trace_cfg_pkg::off_int_status, d);
    chk("int_status", 32'(ist), d);
    cmd(trace_cfg_pkg::op_count, 0, 0, 0);
    @(negedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    cmd(trace_cfg_pkg::op_count, 0, 0, 5);
    @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    test_done();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    test_done();
  end
endmodule
